/* logic/qsc_regs.svh */
/*
 * qsc_regs.svh: register offsets, field positions, reset values and
 * widths of the quadrature status and counter block.
 * Assumes a 32-bit apb slave with 12-bit byte addresses, one word per register.
 */
`ifndef QSC_REGS_SVH
`define QSC_REGS_SVH

`define QSC_ADDR_W          12
`define QSC_OFF_CONTROL     12'h000
`define QSC_OFF_IO_CONTROL  12'h004
`define QSC_OFF_EVENT_STAT  12'h008
`define QSC_OFF_POS_HIGH    12'h00C
`define QSC_OFF_POS_LOW     12'h010
`define QSC_OFF_POS_HOLD    12'h014
`define QSC_OFF_VELOCITY    12'h018
`define QSC_OFF_INDEX_HIGH  12'h01C
`define QSC_OFF_INDEX_LOW   12'h020
`define QSC_OFF_GE_COMPARE  12'h024
`define QSC_OFF_LE_COMPARE  12'h028
`define QSC_OFF_INIT_VALUE  12'h02C

`define QSC_CTL_ENABLE_BIT  15
`define QSC_CTL_POSITION_INIT_MODE_LSB   10
`define QSC_IO_SWAP_BIT     8
`define QSC_IO_POL_LSB      4
`define QSC_IO_HOME_BIT     3
`define QSC_IO_INDEX_BIT    2
`define QSC_IO_B_BIT        1
`define QSC_IO_A_BIT        0

`define QSC_EV_INDEX        0
`define QSC_EV_HOME         1
`define QSC_EV_VEL_OV       2
`define QSC_EV_HOMING       3
`define QSC_EV_POS_OV       4
`define QSC_EV_LE           5
`define QSC_EV_GE           6
`define QSC_EV_COUNT        7

`define QSC_MODE_NONE       3'h0
`define QSC_MODE_EVERY_IDX  3'h1
`define QSC_MODE_FIRST_IDX  3'h3
`define QSC_MODE_SECOND_IDX 3'h4

`define QSC_RST_WORD        32'h00000000
`define QSC_POS_MAX         32'hFFFFFFFF
`define QSC_VEL_MAX         16'hFFFF

`endif

/* logic/qsc_pkg.sv */
/*
 * qsc_pkg: types of the quadrature status and counter block.
 * Assumes qsc_regs.svh defines the event count.
 */
`include "qsc_regs.svh"

package qsc_pkg;

    typedef enum logic [1:0] {
        QSC_HOME_WAIT,
        QSC_IDX_FIRST,
        QSC_IDX_SECOND
    } qsc_home_e;

    typedef struct packed {
        logic                      a_m, a_s, b_m, b_s, i_m, i_s, h_m, h_s;
        logic                      a_p, b_p, i_p, h_p;
        logic                      dir_up;
        logic                      enable;
        logic [2:0]                position_init_mode;
        logic                      swap;
        logic [3:0]                pol;
        logic [`QSC_EV_COUNT-1:0]  flags;
        logic [`QSC_EV_COUNT-1:0]  irq_en;
        logic [31:0]               pos;
        logic [15:0]               hold;
        logic [15:0]               vel;
        logic [31:0]               idx;
        logic [31:0]               gec;
        logic [31:0]               lec;
        logic [31:0]               init;
        qsc_home_e                 home_st;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
        logic                      irq;
    } qsc_state_s;

endpackage

/* logic/qsc_counters.sv */
/*
 * qsc_counters: status flags, event enables and position, velocity and
 * index counters of a quadrature encoder interface, behind an apb slave.
 * Assumes encoder pins are asynchronous and unfiltered; pclk at 20 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
`include "qsc_regs.svh"

module qsc_counters (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`QSC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    phase_a_pin,
    input  wire logic                    phase_b_pin,
    input  wire logic                    index_pin,
    input  wire logic                    home_pin,
    output logic                         irq_request
);

    qsc_pkg::qsc_state_s s_q;
    qsc_pkg::qsc_state_s s_d;

    logic                      a_pol, b_pol, a_c, b_c, idx_c, home_c;
    logic                      idx_ev, home_ev, step, up, run;
    logic                      access, setup_rd, wr_done, mapped;
    logic [31:0]               rd_val;
    logic [`QSC_EV_COUNT-1:0]  ev_set;
    logic                      home_mode, load_init;

    // packs flags and enables into the status word layout
    function automatic logic [15:0] status_word(input logic [`QSC_EV_COUNT-1:0] f,
                                                input logic [`QSC_EV_COUNT-1:0] e);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 0; i < `QSC_EV_COUNT; i++) begin
            w[2*i+1] = f[i];
            w[2*i]   = e[i];
        end
        return w;
    endfunction

    function automatic logic is_mapped(input logic [`QSC_ADDR_W-1:0] a);
        return (a == `QSC_OFF_CONTROL)    || (a == `QSC_OFF_IO_CONTROL) ||
               (a == `QSC_OFF_EVENT_STAT) || (a == `QSC_OFF_POS_HIGH)   ||
               (a == `QSC_OFF_POS_LOW)    || (a == `QSC_OFF_POS_HOLD)   ||
               (a == `QSC_OFF_VELOCITY)   || (a == `QSC_OFF_INDEX_HIGH) ||
               (a == `QSC_OFF_INDEX_LOW)  || (a == `QSC_OFF_GE_COMPARE) ||
               (a == `QSC_OFF_LE_COMPARE) || (a == `QSC_OFF_INIT_VALUE);
    endfunction

    always_comb begin
        s_d = s_q;

        // two-flop synchronisers; first stage read only by the second
        s_d.a_m = phase_a_pin;
        s_d.a_s = s_q.a_m;
        s_d.b_m = phase_b_pin;
        s_d.b_s = s_q.b_m;
        s_d.i_m = index_pin;
        s_d.i_s = s_q.i_m;
        s_d.h_m = home_pin;
        s_d.h_s = s_q.h_m;

        // pol[0] a, pol[1] b, pol[2] index, pol[3] home
        a_pol  = s_q.a_s ^ s_q.pol[0];
        b_pol  = s_q.b_s ^ s_q.pol[1];
        a_c    = s_q.swap ? b_pol : a_pol;
        b_c    = s_q.swap ? a_pol : b_pol;
        idx_c  = s_q.i_s ^ s_q.pol[2];
        home_c = s_q.h_s ^ s_q.pol[3];

        s_d.a_p = a_c;
        s_d.b_p = b_c;
        s_d.i_p = idx_c;
        s_d.h_p = home_c;

        idx_ev  = idx_c & ~s_q.i_p;
        home_ev = home_c & ~s_q.h_p;
        // a double transition is a lost step; it is dropped, not guessed
        step    = (a_c ^ s_q.a_p) ^ (b_c ^ s_q.b_p);
        up      = (s_q.a_p == b_c);
        run     = s_q.enable;

        ev_set = '0;
        ev_set[`QSC_EV_INDEX] = idx_ev;
        ev_set[`QSC_EV_HOME]  = home_ev;
        ev_set[`QSC_EV_GE]    = $signed(s_q.pos) >= $signed(s_q.gec);
        ev_set[`QSC_EV_LE]    = $signed(s_q.pos) <= $signed(s_q.lec);

        if (run && step) begin
            s_d.dir_up = up;
            s_d.pos    = up ? s_q.pos + 32'h00000001 : s_q.pos - 32'h00000001;
            s_d.vel    = up ? s_q.vel + 16'h0001 : s_q.vel - 16'h0001;
            ev_set[`QSC_EV_POS_OV] = up ? (s_q.pos == `QSC_POS_MAX)
                                        : (s_q.pos == `QSC_RST_WORD);
            ev_set[`QSC_EV_VEL_OV] = up ? (s_q.vel == `QSC_VEL_MAX)
                                        : (s_q.vel == 16'h0000);
        end

        if (run && idx_ev) begin
            s_d.idx = s_q.dir_up ? s_q.idx + 32'h00000001 : s_q.idx - 32'h00000001;
        end

        // homing: arm on home, load on first or second index after it
        home_mode = (s_q.position_init_mode == `QSC_MODE_FIRST_IDX) ||
                    (s_q.position_init_mode == `QSC_MODE_SECOND_IDX);
        load_init = 1'b0;
        if (!run || !home_mode) begin
            s_d.home_st = qsc_pkg::QSC_HOME_WAIT;
        end else begin
            case (s_q.home_st)
                qsc_pkg::QSC_HOME_WAIT: begin
                    if (home_ev) begin
                        s_d.home_st = qsc_pkg::QSC_IDX_FIRST;
                    end
                end
                qsc_pkg::QSC_IDX_FIRST: begin
                    if (idx_ev) begin
                        if (s_q.position_init_mode == `QSC_MODE_FIRST_IDX) begin
                            load_init   = 1'b1;
                            s_d.home_st = qsc_pkg::QSC_HOME_WAIT;
                        end else begin
                            s_d.home_st = qsc_pkg::QSC_IDX_SECOND;
                        end
                    end
                end
                qsc_pkg::QSC_IDX_SECOND: begin
                    if (idx_ev) begin
                        load_init   = 1'b1;
                        s_d.home_st = qsc_pkg::QSC_HOME_WAIT;
                    end
                end
                default: s_d.home_st = qsc_pkg::QSC_HOME_WAIT;
            endcase
        end
        if (load_init) begin
            s_d.pos = s_q.init;
            ev_set[`QSC_EV_HOMING] = 1'b1;
        end
        if (run && idx_ev && (s_q.position_init_mode == `QSC_MODE_EVERY_IDX)) begin
            s_d.pos = `QSC_RST_WORD;
        end

        // apb: one wait state so read data leaves a flop
        access   = psel & penable;
        mapped   = is_mapped(paddr);
        setup_rd = access & ~s_q.pready & ~pwrite;
        wr_done  = access & s_q.pready & pwrite & ~s_q.pslverr;

        case (paddr)
            `QSC_OFF_CONTROL:    rd_val = {16'h0000, s_q.enable, 2'b00, s_q.position_init_mode, 10'h000};
            `QSC_OFF_IO_CONTROL: rd_val = {23'h000000, s_q.swap, s_q.pol[3], s_q.pol[2],
                                           s_q.pol[1], s_q.pol[0], home_c, idx_c,
                                           b_c, a_c};
            `QSC_OFF_EVENT_STAT: rd_val = {16'h0000, status_word(s_q.flags, s_q.irq_en)};
            `QSC_OFF_POS_HIGH:   rd_val = {16'h0000, s_q.pos[31:16]};
            `QSC_OFF_POS_LOW:    rd_val = {16'h0000, s_q.pos[15:0]};
            `QSC_OFF_POS_HOLD:   rd_val = {16'h0000, s_q.hold};
            `QSC_OFF_VELOCITY:   rd_val = {16'h0000, s_q.vel};
            `QSC_OFF_INDEX_HIGH: rd_val = {16'h0000, s_q.idx[31:16]};
            `QSC_OFF_INDEX_LOW:  rd_val = {16'h0000, s_q.idx[15:0]};
            `QSC_OFF_GE_COMPARE: rd_val = s_q.gec;
            `QSC_OFF_LE_COMPARE: rd_val = s_q.lec;
            `QSC_OFF_INIT_VALUE: rd_val = s_q.init;
            default:             rd_val = `QSC_RST_WORD;
        endcase

        if (access && !s_q.pready) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = ~mapped;
            // writes leave the last read data standing
            if (!pwrite) begin
                s_d.prdata = rd_val;
            end
        end else begin
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
        end

        // hold captured with the same snapshot the low word is read from
        if (setup_rd && (paddr == `QSC_OFF_POS_LOW)) begin
            s_d.hold = s_q.pos[31:16];
        end

        // sticky flags: set wins over the clear of a zero written
        for (int i = 0; i < `QSC_EV_COUNT; i++) begin
            if (wr_done && (paddr == `QSC_OFF_EVENT_STAT) && !pwdata[2*i+1]) begin
                s_d.flags[i] = 1'b0;
            end
            if (ev_set[i]) begin
                s_d.flags[i] = 1'b1;
            end
        end

        // software writes override the counters in the same cycle
        if (wr_done) begin
            case (paddr)
                `QSC_OFF_CONTROL: begin
                    s_d.enable = pwdata[`QSC_CTL_ENABLE_BIT];
                    s_d.position_init_mode  = pwdata[`QSC_CTL_POSITION_INIT_MODE_LSB +: 3];
                end
                `QSC_OFF_IO_CONTROL: begin
                    s_d.swap = pwdata[`QSC_IO_SWAP_BIT];
                    s_d.pol  = pwdata[`QSC_IO_POL_LSB +: 4];
                end
                `QSC_OFF_EVENT_STAT: begin
                    for (int i = 0; i < `QSC_EV_COUNT; i++) begin
                        s_d.irq_en[i] = pwdata[2*i];
                    end
                end
                `QSC_OFF_POS_HIGH:   s_d.pos[31:16] = pwdata[15:0];
                `QSC_OFF_POS_LOW:    s_d.pos = {s_q.hold, pwdata[15:0]};
                `QSC_OFF_POS_HOLD:   s_d.hold = pwdata[15:0];
                `QSC_OFF_VELOCITY:   s_d.vel = pwdata[15:0];
                `QSC_OFF_INDEX_HIGH: s_d.idx[31:16] = pwdata[15:0];
                `QSC_OFF_INDEX_LOW:  s_d.idx[15:0] = pwdata[15:0];
                `QSC_OFF_GE_COMPARE: s_d.gec = pwdata;
                `QSC_OFF_LE_COMPARE: s_d.lec = pwdata;
                `QSC_OFF_INIT_VALUE: s_d.init = pwdata;
                default: s_d.init = s_q.init;
            endcase
        end

        // one cycle behind the flags so the output leaves a flop
        s_d.irq = |(s_q.flags & s_q.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q         <= '0;
            s_q.home_st <= qsc_pkg::QSC_HOME_WAIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata      = s_q.prdata;
    assign pready      = s_q.pready;
    assign pslverr     = s_q.pslverr;
    assign irq_request = s_q.irq;

endmodule // qsc_counters
`default_nettype wire

/* verification/qsc_encoder_model.sv */
/* qsc_encoder_model: incremental encoder, phase a/b in gray order, index, home.
   assumes the bench pulses step_fwd one cycle per quarter step. */
`timescale 1ns/1ps
`default_nettype none
module qsc_encoder_model (
    input  wire logic pclk,
    input  wire logic step_fwd,
    input  wire logic index_lvl,
    input  wire logic home_lvl,
    output logic      phase_a_pin,
    output logic      phase_b_pin,
    output logic      index_pin,
    output logic      home_pin
);
    logic [1:0] ph_q;
    initial ph_q = 2'h0;
    always @(posedge pclk) begin
        if (step_fwd) begin
            ph_q <= ph_q + 2'h1;
        end
    end
    // a,b: 00 10 11 01, a leads b going forward; spacing set by the bench
    assign phase_a_pin = ph_q[1] ^ ph_q[0];
    assign phase_b_pin = ph_q[1];
    assign index_pin   = index_lvl;
    assign home_pin    = home_lvl;
endmodule // qsc_encoder_model
`default_nettype wire

/* verification/qsc_counters_assertions.sv */
/* qsc_counters_assertions: apb timing and read-data checks on the ports.
   assumes qsc_regs.svh on the include path; bound below. */
`timescale 1ns/1ps
`default_nettype none
`include "qsc_regs.svh"
module qsc_counters_assertions (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`QSC_ADDR_W-1:0] paddr,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   irq_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_ok;
    assign rd_ok = pready && psel && !pwrite;
    a_one_wait:
        assert property ($rose(penable) && psel |=> pready) else $error("no answer");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("ready held");
    a_idle_quiet:
        assert property (!(psel && penable) |=> !pready) else $error("stray ready");
    a_err_with_ready:
        assert property (pslverr |-> pready && psel) else $error("stray error");
    a_unmapped_err:
        assert property ($rose(penable) && psel && paddr > `QSC_OFF_INIT_VALUE |=> pslverr)
        else $error("unmapped not refused");
    a_mapped_ok:
        assert property ($rose(penable) && psel && paddr <= `QSC_OFF_INIT_VALUE
            && paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped refused");
    a_stat_top_zero:
        assert property (rd_ok && paddr == `QSC_OFF_EVENT_STAT |-> prdata[31:14] == 18'h0)
        else $error("status top bits set");
    a_narrow_upper:
        assert property (rd_ok && (paddr == `QSC_OFF_POS_HOLD || paddr == `QSC_OFF_VELOCITY)
            |-> prdata[31:16] == 16'h0000) else $error("narrow reg upper bits");
    a_rdata_on_read:
        assert property ($changed(prdata) |-> rd_ok) else $error("read data moved");
    a_reset_quiet:
        assert property ($rose(presetn) |-> !pready && !irq_request) else $error("busy at reset");
    c_stat_read: cover property (rd_ok && paddr == `QSC_OFF_EVENT_STAT);
    c_refused: cover property (pslverr);
    c_irq: cover property (irq_request);
endmodule // qsc_counters_assertions
bind qsc_counters qsc_counters_assertions u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .irq_request);
`default_nettype wire

/* verification/qsc_counters_tb_top.sv */
/* qsc_counters_tb_top: self-checking bench, apb master plus encoder model.
   assumes qsc_regs.svh, the encoder model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "qsc_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module qsc_counters_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rdv;
    logic        pready, pslverr, irq_request, errv;
    logic        step_fwd = 1'b0, index_lvl = 1'b0, home_lvl = 1'b0;
    logic        pa, pb, pi, ph;
    int          bad_count = 0, checks = 0;
    always #25 pclk = ~pclk;
    qsc_encoder_model ENC (.pclk, .step_fwd, .index_lvl, .home_lvl,
        .phase_a_pin(pa), .phase_b_pin(pb), .index_pin(pi), .home_pin(ph));
    qsc_counters DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .phase_a_pin(pa), .phase_b_pin(pb),
        .index_pin(pi), .home_pin(ph), .irq_request);
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // request held until pready is sampled; one idle cycle after
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        errv = pslverr;
        if (n >= 20) bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h00000000);
    endtask
    task automatic set_pos(input logic [31:0] v);
        wr(`QSC_OFF_POS_HOLD, {16'h0000, v[31:16]});
        wr(`QSC_OFF_POS_LOW, {16'h0000, v[15:0]});
    endtask
    // pins pass two sync flops, so give each change a few cycles
    task automatic step(input int n);
        repeat (n) begin
            step_fwd <= 1'b1;
            @(posedge pclk);
            step_fwd <= 1'b0;
            wait_n(4);
        end
    endtask
    task automatic pulse(input logic home);
        if (home) home_lvl <= 1'b1; else index_lvl <= 1'b1;
        wait_n(6);
        if (home) home_lvl <= 1'b0; else index_lvl <= 1'b0;
        wait_n(6);
    endtask
    task automatic t_reset;
        for (int a = 0; a <= 44; a += 4) begin
            rd(a[11:0]);
            if (a == 8) rdv = rdv & 32'hFFFFD7FF; // compare flags may track
            `CHK("reset value", 32'h00000000, rdv)
        end
        rd(12'h030);
        `CHK("unmapped error", 1'b1, errv)
        $display("t_reset done");
    endtask
    task automatic t_pins;
        step(1);
        rd(`QSC_OFF_IO_CONTROL);
        `CHK("pin status", 4'h1, rdv[3:0])
        wr(`QSC_OFF_IO_CONTROL, 32'h00000140);
        wait_n(4);
        rd(`QSC_OFF_IO_CONTROL);
        `CHK("swap and index inverted", 4'h6, rdv[3:0])
        wr(`QSC_OFF_IO_CONTROL, 32'h00000010);
        wait_n(4);
        rd(`QSC_OFF_IO_CONTROL);
        `CHK("phase a inverted", 4'h0, rdv[3:0])
        wr(`QSC_OFF_IO_CONTROL, 32'h00000000);
        rd(`QSC_OFF_POS_LOW);
        `CHK("disabled count", 32'h00000000, rdv)
        $display("t_pins done");
    endtask
    task automatic t_count;
        wr(`QSC_OFF_CONTROL, 32'h00008000);
        wr(`QSC_OFF_EVENT_STAT, 32'h00000000);
        step(4);
        rd(`QSC_OFF_POS_LOW);
        `CHK("position", 32'h00000004, rdv)
        pulse(1'b0);
        pulse(1'b1);
        rd(`QSC_OFF_EVENT_STAT);
        `CHK("index home flags", 2'h3, {rdv[3], rdv[1]})
        `CHK("irq masked", 1'b0, irq_request)
        rd(`QSC_OFF_INDEX_LOW);
        `CHK("index count", 32'h00000001, rdv)
        wr(`QSC_OFF_EVENT_STAT, 32'h0000000B);
        wait_n(2);
        `CHK("irq enabled", 1'b1, irq_request)
        wr(`QSC_OFF_EVENT_STAT, 32'h00000009);
        wr(`QSC_OFF_EVENT_STAT, 32'h0000000B);
        wait_n(2);
        `CHK("irq cleared", 1'b0, irq_request)
        rd(`QSC_OFF_EVENT_STAT);
        `CHK("flags after clear", 4'h9, rdv[3:0])
        $display("t_count done");
    endtask
    task automatic t_pos;
        set_pos(32'h12345678);
        rd(`QSC_OFF_POS_HIGH);
        `CHK("pos high", 32'h00001234, rdv)
        rd(`QSC_OFF_POS_LOW);
        `CHK("pos low", 32'h00005678, rdv)
        rd(`QSC_OFF_POS_HOLD);
        `CHK("hold", 32'h00001234, rdv)
        set_pos(32'hFFFFFFFF);
        wr(`QSC_OFF_VELOCITY, 32'h0000FFFF);
        rd(`QSC_OFF_VELOCITY);
        `CHK("velocity", 32'h0000FFFF, rdv)
        wr(`QSC_OFF_EVENT_STAT, 32'h00000000);
        step(1);
        rd(`QSC_OFF_POS_LOW);
        `CHK("wrapped low", 32'h00000000, rdv)
        rd(`QSC_OFF_POS_HOLD);
        `CHK("wrapped hold", 32'h00000000, rdv)
        rd(`QSC_OFF_EVENT_STAT);
        `CHK("overflow flags", 2'h3, {rdv[9], rdv[5]})
        $display("t_pos done");
    endtask
    task automatic t_cmp;
        set_pos(32'h00000010);
        wr(`QSC_OFF_GE_COMPARE, 32'h00000100);
        wr(`QSC_OFF_LE_COMPARE, 32'h00000000);
        wr(`QSC_OFF_EVENT_STAT, 32'h00000000);
        rd(`QSC_OFF_EVENT_STAT);
        `CHK("between limits", 2'h0, {rdv[13], rdv[11]})
        set_pos(32'h00000100);
        rd(`QSC_OFF_EVENT_STAT);
        `CHK("at ge limit", 2'h2, {rdv[13], rdv[11]})
        set_pos(32'h00000000);
        rd(`QSC_OFF_EVENT_STAT);
        `CHK("at le limit", 1'b1, rdv[11])
        $display("t_cmp done");
    endtask
    task automatic t_home;
        wr(`QSC_OFF_INIT_VALUE, 32'h0000ABCD);
        for (int m = 3; m <= 4; m++) begin
            wr(`QSC_OFF_CONTROL, 32'h00008000 | (m << 10));
            set_pos(32'h00000007);
            wr(`QSC_OFF_EVENT_STAT, 32'h00000000);
            pulse(1'b1);
            pulse(1'b0);
            if (m == 4) begin
                rd(`QSC_OFF_POS_LOW);
                `CHK("not yet loaded", 32'h00000007, rdv)
                pulse(1'b0);
            end
            rd(`QSC_OFF_POS_LOW);
            `CHK("loaded", 32'h0000ABCD, rdv)
            rd(`QSC_OFF_EVENT_STAT);
            `CHK("homing done", 1'b1, rdv[7])
        end
        wr(`QSC_OFF_CONTROL, 32'h00008400);
        set_pos(32'h00000055);
        pulse(1'b0);
        rd(`QSC_OFF_POS_LOW);
        `CHK("index reset", 32'h00000000, rdv)
        $display("t_home done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        wait_n(6);
        presetn <= 1'b1;
        t_reset;
        t_pins;
        t_count;
        t_pos;
        t_cmp;
        t_home;
        wrap_up;
    end
    // whole run is well under a thousand cycles
    initial begin
        wait_n(5000);
        bad_count++;
        wrap_up;
    end
endmodule // qsc_counters_tb_top
`default_nettype wire
